// ---- shared/frame_capture_pkg.sv ----
`default_nettype none

package frame_capture_pkg;

  // Clock and frame timing
  localparam longint CLK_FREQ_HZ     = 100_000_000;
  localparam longint FREE_FPS_X10    = 93;
  localparam longint PRECISE_FPS_X10 = 46;
  // Least frame time, so round the cycle count up
  localparam longint FRAME_CYCLES_L  = (CLK_FREQ_HZ * 10 + FREE_FPS_X10 - 1) / FREE_FPS_X10;
  localparam int     FRAME_CYCLES    = int'(FRAME_CYCLES_L);
  // Exposure begins a quarter into each frame cycle
  localparam int     EXPO_DIVISOR    = 4;
  localparam int     EXPO_OFFSET     = FRAME_CYCLES / EXPO_DIVISOR;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_FREE    = 2'h0,
    MODE_FAST    = 2'h1,
    MODE_PRECISE = 2'h2
  } trig_mode_e;

  // Capture sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SETUP   = 4'h2,
    ST_WAIT    = 4'h4,
    ST_CAPTURE = 4'h8
  } cap_state_e;

  // Indications toward trigger source and host image path
  typedef struct packed {
    logic expo_out;
    logic frame_start;
    logic img_deliver;
    logic img_drop;
  } cap_out_s;

  localparam cap_out_s CAP_OUT_RST = '{expo_out: 1'b0, frame_start: 1'b0, img_deliver: 1'b0, img_drop: 1'b0};

endpackage

`default_nettype wire

// ---- src/frame_cycle_timer.sv ----
`default_nettype none

module frame_cycle_timer #(
  parameter int FRAME_CYCLES = 8,
  parameter int EXPO_OFFSET  = 2
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic restart,
  output logic      cyc_zero,
  output logic      expo_phase,
  output logic      frame_last
);

  localparam int CW = $clog2(FRAME_CYCLES);
  localparam logic [CW-1:0] LAST_CNT = CW'(FRAME_CYCLES - 1);
  localparam logic [CW-1:0] EXPO_CNT = CW'(EXPO_OFFSET);

  // Exposure must start inside the cycle and after its first clock
  if (FRAME_CYCLES < 4 || EXPO_OFFSET < 1 || EXPO_OFFSET >= FRAME_CYCLES) begin : g_bad
    $error("frame_cycle_timer: exposure offset outside frame cycle");
  end

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Decode of cycle position
  assign frame_last = (cnt_ff == LAST_CNT);
  assign cyc_zero   = (cnt_ff == '0);
  assign expo_phase = (cnt_ff >= EXPO_CNT);
  // Restart wins over wrap so a trigger always rebases the cycle
  assign nxt_cnt    = (restart || frame_last) ? '0 : cnt_ff + CW'(1);

  // Free-running position counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

`default_nettype wire

// ---- src/trigger_mode_frame_capture.sv ----
`default_nettype none

module trigger_mode_frame_capture
  import frame_capture_pkg::*;
#(
  parameter int FRAME_CYCLES = frame_capture_pkg::FRAME_CYCLES,
  parameter int EXPO_OFFSET  = frame_capture_pkg::EXPO_OFFSET
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic                           clk_en,
  input  wire frame_capture_pkg::trig_mode_e  trig_mode,
  input  wire logic                           trigger,
  output frame_capture_pkg::cap_out_s         cap_out,
  output frame_capture_pkg::cap_state_e       cap_state
);
  import frame_capture_pkg::*;

  // Helper counters span two frames
  localparam int JW = $clog2(2 * FRAME_CYCLES + 1);
  localparam logic [JW-1:0] JIT_MAX   = JW'(2 * FRAME_CYCLES);
  localparam logic [JW-1:0] SETUP_END = JW'(FRAME_CYCLES - 1);

  if (JW > 31) begin : g_bad
    $error("trigger_mode_frame_capture: frame cycle count too large");
  end

  logic       cyc_zero;
  logic       expo_phase;
  logic       frame_last;
  logic       trig_prev_ff;
  logic       restart;
  cap_state_e st_ff;
  cap_state_e nxt_st;
  cap_out_s   out_ff;
  cap_out_s   nxt_out;

  //////////////////////////////////////////////////////////////////////////////
  // Frame cycle of the sensor
  frame_cycle_timer #(
    .FRAME_CYCLES (FRAME_CYCLES),
    .EXPO_OFFSET  (EXPO_OFFSET)
  ) u_timer (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .restart    (restart),
    .cyc_zero   (cyc_zero),
    .expo_phase (expo_phase),
    .frame_last (frame_last)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode and trigger decode; an unused mode code behaves as free run
  wire mode_fast    = (trig_mode == MODE_FAST);
  wire mode_precise = (trig_mode == MODE_PRECISE);
  wire mode_free    = !mode_fast && !mode_precise;
  wire trig_rise    = trigger && !trig_prev_ff;
  // Free run never looks at the trigger
  wire idle         = (st_ff == ST_IDLE);
  wire fast_take    = idle && mode_fast && trig_rise;
  // Wrap edge counts as before exposure: the new cycle begins next
  wire fast_early   = fast_take && (!expo_phase || frame_last);
  wire fast_late    = fast_take && expo_phase && !frame_last;
  // Busy precise capture ignores triggers, halving the rate
  wire prec_take    = idle && mode_precise && trig_rise;
  assign restart    = prec_take;
  wire capturing    = (st_ff == ST_CAPTURE);
  // Free run delivers even on the cycle it abandons a pending capture
  wire deliver      = frame_last && (capturing || mode_free);

  // Sequencer next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (fast_early) begin
          nxt_st = ST_CAPTURE;
        end else if (fast_late) begin
          nxt_st = ST_WAIT;
        end else if (prec_take) begin
          nxt_st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (frame_last) begin
          nxt_st = ST_CAPTURE;
        end
      end
      ST_WAIT: begin
        if (frame_last) begin
          nxt_st = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (frame_last) begin
          nxt_st = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    // Leaving the triggered modes abandons any capture
    if (mode_free) begin
      nxt_st = ST_IDLE;
    end
  end

  // Registered indications
  always_comb begin
    nxt_out             = CAP_OUT_RST;
    nxt_out.expo_out    = expo_phase && !frame_last && !restart && (mode_free || capturing);
    nxt_out.frame_start = frame_last || restart;
    nxt_out.img_deliver = deliver;
    nxt_out.img_drop    = frame_last && !deliver;
  end

  // State, trigger history and outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= ST_IDLE;
      trig_prev_ff <= 1'b0;
      out_ff       <= CAP_OUT_RST;
    end else if (clk_en) begin
      st_ff        <= nxt_st;
      trig_prev_ff <= trigger;
      out_ff       <= nxt_out;
    end
  end

  assign cap_out   = out_ff;
  assign cap_state = st_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks: helper counters measure trigger to fast delivery and to precise setup end
  logic [JW-1:0] fast_cnt_ff;
  logic [JW-1:0] prec_cnt_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_cnt_ff <= '0;
      prec_cnt_ff <= '0;
    end else if (clk_en) begin
      fast_cnt_ff <= fast_take ? '0 : fast_cnt_ff + JW'(1);
      prec_cnt_ff <= prec_take ? '0 : prec_cnt_ff + JW'(1);
    end
  end

  sequence s_prec_trig;
    clk_en && prec_take;
  endsequence

  sequence s_setup_end;
    clk_en && st_ff == ST_SETUP && frame_last;
  endsequence

  a_free_stays_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && mode_free |=> st_ff == ST_IDLE)
    else $error("free run left idle state");

  a_free_every_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && mode_free && frame_last |=> out_ff.img_deliver && !out_ff.img_drop)
    else $error("free run frame not delivered");

  a_fast_capture_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && capturing && frame_last && !mode_free |=> out_ff.img_deliver ##0 st_ff == ST_IDLE)
    else $error("fast capture end did not deliver");

  a_fast_early_pick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && idle && mode_fast && trig_rise && !expo_phase |=> st_ff == ST_CAPTURE && !out_ff.img_drop)
    else $error("early fast trigger not taken in same cycle");

  a_fast_late_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && fast_late |=> st_ff == ST_WAIT ##0 (!out_ff.img_deliver throughout (st_ff == ST_WAIT)))
    else $error("late fast trigger did not skip cycle");

  a_fast_jitter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && capturing && frame_last && mode_fast |-> fast_cnt_ff < JIT_MAX)
    else $error("fast trigger delivery beyond two frames");

  a_prec_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_prec_trig |=> cyc_zero && st_ff == ST_SETUP && out_ff.frame_start)
    else $error("precise trigger did not restart cycle");

  a_prec_setup_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_setup_end and !mode_free |=> out_ff.img_drop && !out_ff.img_deliver && st_ff == ST_CAPTURE)
    else $error("precise setup cycle not dropped");

  a_prec_fixed_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_setup_end and mode_precise |-> prec_cnt_ff == SETUP_END)
    else $error("precise second cycle not one frame after trigger");

  a_prec_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !idle && !frame_last && trig_rise |=> !cyc_zero)
    else $error("trigger restarted cycle during capture");

  a_free_no_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && mode_free && trig_rise && !frame_last |=> !cyc_zero && !out_ff.img_drop)
    else $error("trigger disturbed free run");

endmodule

`default_nettype wire

// ---- tb/trigger_host_model.sv ----
`default_nettype none

module trigger_host_model
  import frame_capture_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        fire,
  input  wire logic [3:0]                  hold,
  input  wire frame_capture_pkg::cap_out_s cap_out,
  output logic                             trigger,
  output var int                           delivered
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] left_ff = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source: a slow source keeps the line up for hold cycles
  assign trigger = fire | (left_ff != 4'h0);

  always @(posedge sys_clk) begin
    if (fire) begin
      left_ff <= hold - 4'h1;
    end else if (left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host receiver: counts every image handed over
  initial delivered = 0;

  always @(posedge sys_clk) begin
    if (cap_out.img_deliver === 1'b1) begin
      delivered <= delivered + 1;
    end
  end
endmodule

`default_nettype wire

// ---- tb/test_trigger_mode_frame_capture.sv ----
`default_nettype none

module test_trigger_mode_frame_capture;
  import frame_capture_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // Short frame keeps the run brief
  localparam int FC     = 16;
  localparam int EO     = 4;
  localparam int EXPO_N = FC - EO - 1;

  logic       sys_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic       clk_en    = 1'b1;
  logic       fire      = 1'b0;
  logic [3:0] hold      = 4'h1;
  trig_mode_e trig_mode = MODE_FREE;
  logic       trigger;
  cap_out_s   cap_out;
  cap_state_e cap_state;
  int         delivered;
  int         d0;
  int         fails     = 0;
  int         checks    = 0;

  always #5 sys_clk = ~sys_clk;

  trigger_mode_frame_capture #(.FRAME_CYCLES(FC), .EXPO_OFFSET(EO)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .trig_mode(trig_mode),
    .trigger(trigger), .cap_out(cap_out), .cap_state(cap_state));

  trigger_host_model u_partner (
    .sys_clk(sys_clk), .fire(fire), .hold(hold), .cap_out(cap_out),
    .trigger(trigger), .delivered(delivered));

  ////////////////////////////////////////////////////////////////////////////
  task chk_num(input string nm, input int exp, input int got);
    checks++;
    if (exp != got) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task chk_vec(input string nm, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (exp !== got) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task close_out;
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Bounded wait for a frame boundary, so a dead sequencer cannot hang us
  task sync;
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (cap_out.frame_start === 1'b1) return;
    end
    chk_num("frame start seen", 1, 0);
  endtask

  // One frame from a boundary; trigger at cycle at, 2'b11 skips the image check
  task automatic frame(input int at, input int el, input int ee, input logic [1:0] edd, input cap_state_e est);
    int len;
    int expo;
    len  = 0;
    expo = 0;
    for (int i = 0; i < 40; i++) begin
      fire = (len == at);
      @(negedge sys_clk);
      len++;
      if (cap_out.expo_out === 1'b1) expo++;
      if (cap_out.frame_start === 1'b1) break;
    end
    fire = 1'b0;
    chk_num("frame length", el, len);
    if (ee >= 0) chk_num("exposure cycles", ee, expo);
    if (edd != 2'b11) chk_vec("deliver drop", {2'b00, edd}, {2'b00, cap_out.img_deliver, cap_out.img_drop});
    chk_vec("state", est, cap_state);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_free;
    frame(5, FC, EXPO_N, 2'b10, ST_IDLE);
    frame(-1, FC, EXPO_N, 2'b10, ST_IDLE);
  endtask

  // Enable low mid-exposure: outputs hold and the frame stretches
  task t_freeze;
    repeat (8) @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_vec("frozen outputs", 4'h8, cap_out);
    clk_en = 1'b1;
    frame(-1, FC - 8, EXPO_N - 4, 2'b10, ST_IDLE);
  endtask

  task t_fast_early;
    trig_mode = MODE_FAST;
    frame(-1, FC, 0, 2'b01, ST_IDLE);
    frame(0, FC, EXPO_N, 2'b10, ST_IDLE);
  endtask

  // Late trigger: drop this cycle, deliver the next within two periods
  task t_fast_late;
    frame(6, FC, 0, 2'b01, ST_CAPTURE);
    frame(-1, FC, EXPO_N, 2'b10, ST_IDLE);
  endtask

  // Held trigger and a second edge in setup must not restart again
  task t_precise;
    trig_mode = MODE_PRECISE;
    hold      = 4'h3;
    frame(7, 8, -1, 2'b11, ST_SETUP);
    hold      = 4'h1;
    frame(3, FC, 0, 2'b01, ST_CAPTURE);
    frame(-1, FC, EXPO_N, 2'b10, ST_IDLE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    sync;
    d0 = delivered;
    t_free;
    t_freeze;
    t_fast_early;
    t_fast_late;
    t_precise;
    // Let the host count the last pulse; the sync frame counts too
    @(negedge sys_clk);
    chk_num("images delivered", 7, delivered - d0);
    close_out;
  end

  // Watchdog: the sequence needs well under 300 cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    close_out;
  end
endmodule

`default_nettype wire
